// ### verilog/hims_regs.vh
// constants for the host interface mode select block
`ifndef HIMS_REGS_VH
`define HIMS_REGS_VH
`define HIMS_MODE_NONMUX 2'h0
`define HIMS_MODE_MUX 2'h1
`define HIMS_MODE_SERIAL 2'h2
`define HIMS_MODE_RSVD 2'h3
`define HIMS_IRQ_HIGH 2'h0
`define HIMS_IRQ_LOW 2'h1
`define HIMS_IRQ_OD 2'h2
`define HIMS_IRQ_CFG_RST 2'h0
`define HIMS_DATA_RST 8'h00
`endif

// ### verilog/hims_sync.v
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module hims_sync #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
    input wire clk,
    input wire sys_rst,
    input wire [W-1:0] din,
    output reg [W-1:0] dout
);
    reg [W-1:0] meta_reg;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta_reg <= din;
            dout <= meta_reg;
        end
    end
endmodule

// ### verilog/hims_top.v
// host interface mode select and pin steering
// Contract
// - decode select 00/01/10 into three modes
// - dma ack low, used only when enabled
// - dma request driven only while enabled
// - irq output high, low or open drain
// - irq output floats during reset
// - read, write and shift strobes ignored unless select held low
// - low read strobe means read
// - low write strobe means write
// - mode 0 address line, plain data bus
// - mode 1 latch strobe, muxed bus
// - mode 2 shift clock, serial in/out
// - reset restores all configuration
`timescale 1ns/1ps
`include "hims_regs.vh"
module hims_top (
    input wire clk,
    input wire sys_rst,
    input wire [1:0] iface_select_pins,
    input wire cs_n,
    input wire rd_n,
    input wire wr_n,
    input wire reg_select_line,
    input wire dma_ack_n,
    input wire [7:0] data_in,
    output reg [7:0] data_out,
    output reg [7:0] data_oe_n,
    output reg irq_out,
    output reg irq_oe_n,
    input wire dma_enable,
    input wire dma_req_core,
    input wire irq_core,
    input wire [1:0] irq_mode_cfg,
    input wire [7:0] read_data,
    input wire serial_out_core,
    output reg [1:0] mode_reg,
    output reg mode_valid_reg,
    output wire dma_request,
    output wire dma_ack_core,
    output wire rd_cmd,
    output wire wr_cmd,
    output wire reg_select,
    output wire addr_latch,
    output reg [7:0] latched_addr_reg,
    output reg [7:0] wr_data_reg,
    output wire serial_shift_clk,
    output wire serial_in
);
    localparam ST_RESET = 4'b0001;
    localparam ST_SYNC = 4'b0010;
    localparam ST_LATCH = 4'b0100;
    localparam ST_RUN = 4'b1000;
    wire [1:0] sel_s;
    wire [3:0] ctl_s;
    wire [7:0] data_s;
    reg [3:0] state_reg;
    reg [3:0] state_next;
    reg ale_d_reg;
    reg [1:0] irq_cfg_reg;
    wire cs_n_s;
    wire rd_n_s;
    wire wr_n_s;
    wire a_s;
    wire parallel;
    // pin view after the two-flop chains
    wire dma_ack_n_s;
    wire mode_nonmux;
    wire mode_mux;
    wire mode_serial;
    wire serial_drive;
    reg irq_out_next;
    reg irq_oe_n_next;
    reg [7:0] data_out_next;
    reg [7:0] data_oe_n_next;
    hims_sync #(.W(2), .RST_VAL(2'h0)) u_sel (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(iface_select_pins),
        .dout(sel_s)
    );
    // idle-high strobes reset high so nothing fires at release
    hims_sync #(.W(4), .RST_VAL(4'hE)) u_ctl (
        .clk(clk),
        .sys_rst(sys_rst),
        .din({cs_n, rd_n, wr_n, reg_select_line}),
        .dout(ctl_s)
    );
    hims_sync #(.W(8), .RST_VAL(8'h00)) u_dat (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(data_in),
        .dout(data_s)
    );
    // ack pin is asynchronous too; idles high so no false ack at release
    hims_sync #(.W(1), .RST_VAL(1'b1)) u_ack (
        .clk(clk),
        .sys_rst(sys_rst),
        .din(dma_ack_n),
        .dout(dma_ack_n_s)
    );
    assign cs_n_s = ctl_s[3];
    assign rd_n_s = ctl_s[2];
    assign wr_n_s = ctl_s[1];
    assign a_s = ctl_s[0];
    // one decode each so every bus and serial pin function keys on the latched mode
    assign mode_nonmux = mode_valid_reg && mode_reg == `HIMS_MODE_NONMUX;
    assign mode_mux = mode_valid_reg && mode_reg == `HIMS_MODE_MUX;
    assign mode_serial = mode_valid_reg && mode_reg == `HIMS_MODE_SERIAL;
    assign serial_drive = mode_serial && !cs_n_s;
    // mode latched once; later pin changes are not followed
    always @* begin
        state_next = state_reg;
        case (state_reg)
            // two idle cycles let the strap reach the sync output
            ST_RESET: state_next = ST_SYNC;
            ST_SYNC: state_next = ST_LATCH;
            ST_LATCH: state_next = ST_RUN;
            ST_RUN: state_next = ST_RUN;
            default: state_next = ST_RESET;
        endcase
    end
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg <= ST_RESET;
            mode_reg <= `HIMS_MODE_NONMUX;
            mode_valid_reg <= 1'b0;
            irq_cfg_reg <= `HIMS_IRQ_CFG_RST;
        end else begin
            state_reg <= state_next;
            irq_cfg_reg <= irq_mode_cfg;
            if (state_reg == ST_LATCH) begin
                mode_reg <= sel_s;
                mode_valid_reg <= (sel_s != `HIMS_MODE_RSVD);
            end
        end
    end
    // reserved code leaves the bus and serial functions idle; dma still follows dma_enable
    assign parallel = mode_nonmux ||
        mode_mux;
    assign rd_cmd = parallel && !cs_n_s && !rd_n_s;
    assign wr_cmd = parallel && !cs_n_s && !wr_n_s;
    assign reg_select = mode_nonmux && a_s;
    assign addr_latch = mode_mux && a_s;
    assign serial_shift_clk = mode_serial
        && !cs_n_s && wr_n_s;
    assign serial_in = mode_serial && a_s;
    assign dma_request = dma_enable && dma_req_core;
    assign dma_ack_core = dma_enable && !dma_ack_n_s;
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ale_d_reg <= 1'b0;
            latched_addr_reg <= `HIMS_DATA_RST;
            wr_data_reg <= `HIMS_DATA_RST;
        end else begin
            ale_d_reg <= addr_latch;
            // address captured as the latch strobe falls
            if (ale_d_reg && !addr_latch)
                latched_addr_reg <= data_s;
            if (wr_cmd)
                wr_data_reg <= data_s;
        end
    end
    // data pins: enable low means driven
    always @* begin
        data_out_next = `HIMS_DATA_RST;
        data_oe_n_next = 8'hFF;
        if (rd_cmd) begin
            data_out_next = read_data;
            data_oe_n_next = 8'h00;
        end else if (serial_drive) begin
            // only bit 0 carries serial output; the rest stay released
            data_out_next = {7'h00, serial_out_core};
            data_oe_n_next = 8'hFE;
        end
    end
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_out <= `HIMS_DATA_RST;
            data_oe_n <= 8'hFF;
        end else begin
            data_out <= data_out_next;
            data_oe_n <= data_oe_n_next;
        end
    end
    // irq pin: open drain only pulls low
    always @* begin
        irq_out_next = 1'b0;
        irq_oe_n_next = 1'b1;
        case (irq_cfg_reg)
            `HIMS_IRQ_HIGH: begin
                irq_out_next = irq_core;
                irq_oe_n_next = 1'b0;
            end
            `HIMS_IRQ_LOW: begin
                irq_out_next = !irq_core;
                irq_oe_n_next = 1'b0;
            end
            `HIMS_IRQ_OD: begin
                irq_out_next = 1'b0;
                irq_oe_n_next = !irq_core;
            end
            // reserved irq code floats the pin
            default: begin
                irq_out_next = 1'b0;
                irq_oe_n_next = 1'b1;
            end
        endcase
    end
    // registered so the pin never glitches on config changes
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            irq_out <= 1'b0;
            irq_oe_n <= 1'b1;
        end else begin
            irq_out <= irq_out_next;
            irq_oe_n <= irq_oe_n_next;
        end
    end
endmodule

// ### sim/hims_properties.sv
// checker for the mode select block pins
`timescale 1ns/1ps
module hims_properties(
    input wire clk,
    input wire sys_rst,
    input wire cs_n,
    input wire rd_n,
    input wire wr_n,
    input wire dma_ack_n,
    input wire dma_enable,
    input wire dma_req_core,
    input wire [7:0] data_oe_n,
    input wire [1:0] mode_reg,
    input wire dma_request,
    input wire dma_ack_core,
    input wire rd_cmd,
    input wire wr_cmd
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_dma_req_gate: assert property (dma_request == (dma_enable && dma_req_core))
        else $error("dma request ungated");
    a_dma_ack_gate: assert property (dma_ack_core == (dma_enable && !$past(dma_ack_n, 2)))
        else $error("dma ack ungated");
    a_rd_needs_sel: assert property (rd_cmd |-> $past(!cs_n && !rd_n, 2))
        else $error("read without strobe");
    a_wr_needs_sel: assert property (wr_cmd |-> $past(!cs_n && !wr_n, 2))
        else $error("write without strobe");
    a_rd_answer: assert property ($rose(rd_cmd) |-> ##1 data_oe_n == 8'h00)
        else $error("read data late");
    a_data_float: assert property (data_oe_n != 8'hFF |->
        $past(rd_cmd) || (mode_reg == 2'h2 && !$past(cs_n, 3)))
        else $error("data driven idle");
    a_mode_hold: assert property (!$past(sys_rst) && !$past(sys_rst, 2) && !$past(sys_rst, 3)
        && !$past(sys_rst, 4) |-> $stable(mode_reg))
        else $error("mode changed");
    a_no_dual_cmd: assert property (!(rd_cmd && wr_cmd)[*2])
        else $error("read and write");
    c_rd: cover property (rd_cmd);
    c_wr: cover property (wr_cmd);
    c_ack: cover property (dma_ack_core);
    c_serial: cover property (data_oe_n == 8'hFE);
endmodule
bind hims_top hims_properties u_props(.*);

// ### sim/hims_host_model.sv
// host cpu bus model
`timescale 1ns/1ps
module hims_host_model(
    input wire clk,
    input wire [7:0] data_out,
    input wire [7:0] data_oe_n,
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic reg_select_line,
    output logic dma_ack_n,
    output wire [7:0] data_in
);
    logic [7:0] hv;
    // released host bits show inverted last value
    assign data_in = (data_out & ~data_oe_n) | (hv & data_oe_n);
    initial begin
        {cs_n, rd_n, wr_n, reg_select_line, dma_ack_n} = 5'h1D;
        hv = 8'h00;
    end
    task automatic cyc(input logic w, input logic [7:0] d, input logic csh,
        output logic [7:0] q, output logic [7:0] oe);
        @(posedge clk);
        #1 cs_n = csh;
        if (w) hv = d;
        rd_n = w;
        wr_n = !w;
        repeat (5) @(posedge clk);
        #1 q = data_out;
        oe = data_oe_n;
        {cs_n, rd_n, wr_n} = 3'h7;
        hv = ~hv;
    endtask
endmodule

// ### sim/test_host_interface_mode_select.sv
// self-checking bench for mode select block
`timescale 1ns/1ps
module test_host_interface_mode_select;
    logic clk = 0, sys_rst = 1, dma_enable = 0, dma_req_core = 0;
    logic irq_core = 0, serial_out_core = 0, s;
    logic [1:0] iface_select_pins = 2'h0, irq_mode_cfg = 2'h0;
    logic [7:0] read_data = 8'h00, q, oe;
    wire cs_n, rd_n, wr_n, reg_select_line, dma_ack_n, irq_out, irq_oe_n, dma_request;
    wire dma_ack_core, rd_cmd, wr_cmd, mode_valid_reg;
    wire [7:0] data_in, data_out, data_oe_n, wr_data_reg;
    wire [1:0] mode_reg;
    wire reg_select, addr_latch, serial_shift_clk, serial_in;
    wire [7:0] latched_addr_reg;
    logic [3:0] r, seen;
    int errors = 0, comparisons = 0, i, m;
    always #20 clk = ~clk;
    hims_top DUT(.*);
    function automatic logic [1:0] irq_exp(input logic [1:0] cfg, input logic c);
        case (cfg)
            2'h0: irq_exp = {1'b0, c};
            2'h1: irq_exp = {1'b0, !c};
            2'h2: irq_exp = {!c, 1'b0};
            default: irq_exp = 2'h2;
        endcase
    endfunction
    function automatic logic [7:0] oe_exp(input int md, input logic csh, input logic w);
        if (csh) oe_exp = 8'hFF;
        else if (md == 2) oe_exp = 8'hFE;
        else oe_exp = w ? 8'hFF : 8'h00;
    endfunction
    task automatic strobe_a(input logic [7:0] a, output logic [3:0] lv);
        @(posedge clk);
        #1 host.hv = a;
        host.reg_select_line = 1;
        repeat (3) @(posedge clk);
        #1 lv = {reg_select, addr_latch, serial_in, serial_shift_clk};
        host.reg_select_line = 0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    hims_host_model host(.*);
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] v);
        comparisons++;
        if (v !== e) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", n, e, v);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (9000) @(posedge clk);
        errors++;
        complete_run;
    end
    initial begin
        i = $urandom(46346);
        repeat (6) @(posedge clk);
        chk("irq_oe_n", 1, irq_oe_n);
        chk("data_oe_n", 8'hFF, data_oe_n);
        #1 sys_rst = 0;
        repeat (4) @(posedge clk);
        #1 chk("mode", 0, mode_reg);
        for (i = 0; i < 60; i++) begin
            r = $urandom;
            #1 dma_enable = r[0];
            dma_req_core = r[1];
            host.dma_ack_n = !(r[0] & r[2]);
            irq_core = r[3];
            irq_mode_cfg = i[2:1];
            read_data = $urandom;
            s = (i % 5 == 4);
            #1 chk("dma_req", dma_enable & dma_req_core, dma_request);
            host.cyc(i[0], read_data, s, q, oe);
            chk("dma_ack", dma_enable & !host.dma_ack_n, dma_ack_core);
            chk("oe", oe_exp(0, s, i[0]), oe);
            if (!s && !i[0]) chk("rd", read_data, q);
            if (!s && i[0]) chk("wr", read_data, wr_data_reg);
            chk("irq", irq_exp(irq_mode_cfg, irq_core), {irq_oe_n, irq_out});
        end
        $display("test traffic done");
        for (m = 0; m < 3; m++) begin
            #1 sys_rst = 1;
            dma_enable = 0;
            host.dma_ack_n = 1;
            iface_select_pins = m[1:0];
            @(posedge clk);
            #1 chk("irq_oe_n", 1, irq_oe_n);
            chk("mode_rst", 0, mode_reg);
            sys_rst = 0;
            repeat (4) @(posedge clk);
            #1 chk("mode", m, mode_reg);
            chk("mode_valid", 1, mode_valid_reg);
            strobe_a(8'hA5 ^ m[7:0], seen);
            chk("pin_use", {m == 0, m == 1, m == 2, 1'b0}, seen);
            if (m == 1) chk("addr", 8'hA5 ^ m[7:0], latched_addr_reg);
            read_data = $urandom;
            serial_out_core = $urandom;
            host.cyc(0, 8'h00, 0, q, oe);
            chk("oe_mode", oe_exp(m, 0, 0), oe);
            chk("rd_mode", (m == 2) ? {7'h00, serial_out_core} : read_data, q);
        end
        $display("test reset done");
        complete_run;
    end
endmodule
